// *** rtl/pmcs_top.sv ***
// power mode and clock source selector with apb register access
// assumes source ticks, wake and ready inputs synchronous to pclk
//
// Summary of operation
// - gate bit 7 stops cpu; select bits 1:0 pick pri, sec, internal.
// - power-down with gate 0 and select 00 enters sleep, all clocks off.
// - idle modes stop cpu clock, peripherals run from selected source.
// - run modes clock cpu and peripherals from secondary or internal.
// - select writes do not change the source until power-down.
// - clocks stop the cycle after power-down, before the switch.
// - switch waits eight ticks of the new source before resuming.
// - unless primary clocks the system, at most one source flag is set.
// - primary flag set while primary clocks the system and is ready.
// - internal flag set while stable fast internal osc clocks system.
// - secondary flag in timer1 register set while timer1 osc clocks.
// - no flag set means slow rc or unstable fast internal osc.
// - internal primary lets both primary and internal flags be set.
// - moving to internal rc mode clears the primary flag.
// - each power-down samples the bits and enters the mode they name.
// - a different selected source on power-down causes a switch.
// - watchdog wakes from sleep or idle, resets in run modes.
// - idle wake runs on same source, then returns to primary.
// - hardware never alters the gate or select bits.
// - sleep wake waits for primary unless two-speed start is on.
// - interrupt, reset or watchdog returns every mode to primary run.
// - setting select low bit is ignored while secondary osc is off.
// - cpu execution waits about 10 us after an idle wake.
// - sleep shuts the primary oscillator and clears its flag.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
module pmcs_top (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cpu side events
   input wire logic pwr_down_exec,
   input wire logic wake_irq,
   input wire logic wdt_timeout,
   // oscillator status
   input wire logic pri_ready,
   input wire logic pri_is_fast_internal_osc,
   input wire logic fast_internal_osc_stable,
   input wire logic two_speed_en,
   input wire logic pri_tick,
   input wire logic sec_tick,
   input wire logic int_tick,
   // clock control
   output logic cpu_clk_en,
   output logic per_clk_en,
   output logic [1:0] sys_src,
   output logic pri_osc_en,
   output logic wdt_reset,
   output logic cpu_ready
);
   import pmcs_pkg::*;
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   pmcs_state_t state_r, state_nxt;
   pmcs_src_t cur_src_r, tgt_src_r;
   logic tgt_idle_r, tgt_sleep_r, back_pri_r, t1_oscen_r;
   logic [7:0] cfg_r;
   logic prf_r, isf_r, ssf_r;
   logic cpu_clk_en_r, per_clk_en_r, cpu_ready_r;
   logic [1:0] sys_src_r;
   logic pri_osc_en_r, wdt_reset_r;
   logic [31:0] prdata_r;
   logic sw_done, wk_done, sw_start, wk_start;
   logic new_tick, wake_ev, clocked, cfg_gate, cfg_sleep;
   pmcs_src_t cfg_src;
   logic wr_en, mapped;

   assign cfg_gate = cfg_r[GATE_BIT];
   assign cfg_src = pmcs_src_f(cfg_r[1:0]);
   assign cfg_sleep = !cfg_gate && (cfg_src == SRC_PRI);
   assign wake_ev = wake_irq || wdt_timeout;
   assign clocked = (state_r == ST_RUN) || (state_r == ST_IDLE) ||
                    (state_r == ST_WAKE);

   // ---------------------------------------------------------------
   // mode sequencer
   // ---------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN: begin
            if (pwr_down_exec) begin
               state_nxt = ST_STOP;
            end else if (back_pri_r && pri_ready &&
                         cur_src_r != SRC_PRI) begin
               state_nxt = ST_STOP;
            end
         end
         ST_STOP: begin
            if (tgt_sleep_r) begin
               state_nxt = ST_SLEEP;
            end else if (tgt_src_r != cur_src_r) begin
               state_nxt = ST_SWITCH;
            end else if (tgt_idle_r) begin
               state_nxt = ST_IDLE;
            end else begin
               state_nxt = ST_RUN;
            end
         end
         ST_SWITCH: begin
            if (sw_done) begin
               state_nxt = tgt_idle_r ? ST_IDLE : ST_RUN;
            end
         end
         ST_IDLE: begin
            if (wake_ev) begin
               state_nxt = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (wk_done) begin
               state_nxt = ST_RUN;
            end
         end
         ST_SLEEP: begin
            if (wake_ev) begin
               // internal mux clocks meanwhile only with two-speed start
               state_nxt = two_speed_en ? ST_SWITCH : ST_WAITP;
            end
         end
         ST_WAITP: begin
            if (pri_ready) begin
               state_nxt = ST_SWITCH;
            end
         end
         default: begin
            state_nxt = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ---------------------------------------------------------------
   // target latch, sampled only at the power-down strobe
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tgt_src_r <= SRC_PRI;
         tgt_idle_r <= 1'b0;
         tgt_sleep_r <= 1'b0;
      end else if (state_r == ST_RUN && pwr_down_exec) begin
         tgt_src_r <= cfg_src;
         tgt_idle_r <= cfg_gate;
         tgt_sleep_r <= cfg_sleep;
      end else if (state_r == ST_RUN && state_nxt == ST_STOP) begin
         tgt_src_r <= SRC_PRI;
         tgt_idle_r <= 1'b0;
         tgt_sleep_r <= 1'b0;
      end else if (state_r == ST_SLEEP && wake_ev) begin
         tgt_src_r <= two_speed_en ? SRC_INT : SRC_PRI;
         tgt_idle_r <= 1'b0;
         tgt_sleep_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // active source and pending return to primary
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_src_r <= SRC_PRI;
      end else if (state_r == ST_SWITCH && sw_done) begin
         cur_src_r <= tgt_src_r;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         back_pri_r <= 1'b0;
      end else if (state_r == ST_RUN && pwr_down_exec) begin
         back_pri_r <= 1'b0;
      end else if (state_r == ST_RUN && cur_src_r == SRC_PRI) begin
         back_pri_r <= 1'b0;
      end else if (wake_ev && (state_r == ST_IDLE ||
                   state_r == ST_SLEEP)) begin
         back_pri_r <= 1'b1;
      end else if (state_r == ST_RUN && wake_irq) begin
         back_pri_r <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // switch tick counter and wake delay
   // ---------------------------------------------------------------
   always_comb begin
      case (tgt_src_r)
         SRC_PRI: new_tick = pri_tick;
         SRC_SEC: new_tick = sec_tick;
         SRC_INT: new_tick = int_tick;
         default: new_tick = 1'b0;
      endcase
   end

   // ticks are counted only after the stop cycle, so the pause spans
   // about seven to eight periods of the incoming source
   assign sw_start = (state_nxt == ST_SWITCH) &&
                     (state_r != ST_SWITCH);
   assign wk_start = (state_nxt == ST_WAKE) && (state_r != ST_WAKE);

   pmcs_tick_cnt u_tick_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .clr(sw_start),
      .en(state_r == ST_SWITCH),
      .tick(new_tick),
      .done(sw_done)
   );

   pmcs_wake_tmr u_wake_tmr (
      .pclk(pclk),
      .presetn(presetn),
      .start(wk_start),
      .done(wk_done)
   );

   // ---------------------------------------------------------------
   // clock gate outputs
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_clk_en_r <= 1'b1;
         per_clk_en_r <= 1'b1;
         cpu_ready_r <= 1'b1;
      end else begin
         cpu_clk_en_r <= (state_nxt == ST_RUN);
         per_clk_en_r <= (state_nxt == ST_RUN) ||
                         (state_nxt == ST_IDLE) ||
                         (state_nxt == ST_WAKE);
         cpu_ready_r <= (state_nxt == ST_RUN);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_src_r <= SRC_PRI;
      end else if (state_r == ST_SWITCH && sw_done) begin
         sys_src_r <= tgt_src_r;
      end
   end

   // primary stays up only where it clocks the system or is awaited
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pri_osc_en_r <= 1'b1;
      end else if (state_r == ST_STOP) begin
         pri_osc_en_r <= !tgt_sleep_r &&
                         (tgt_src_r == SRC_PRI);
      end else if (back_pri_r || state_r == ST_WAITP) begin
         pri_osc_en_r <= 1'b1;
      end else if (state_r == ST_SLEEP && wake_ev) begin
         pri_osc_en_r <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_reset_r <= 1'b0;
      end else begin
         wdt_reset_r <= (state_r == ST_RUN) && wdt_timeout;
      end
   end

   // ---------------------------------------------------------------
   // source status flags
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prf_r <= 1'b0;
         isf_r <= 1'b0;
         ssf_r <= 1'b0;
      end else begin
         prf_r <= clocked && cur_src_r == SRC_PRI && pri_ready;
         isf_r <= clocked && fast_internal_osc_stable &&
                  (cur_src_r == SRC_INT ||
                   (cur_src_r == SRC_PRI && pri_is_fast_internal_osc));
         ssf_r <= clocked && cur_src_r == SRC_SEC;
      end
   end

   // ---------------------------------------------------------------
   // apb registers
   // ---------------------------------------------------------------
   assign mapped = (paddr == ADDR_CFG) || (paddr == ADDR_T1) ||
                   (paddr == ADDR_MODE);
   assign wr_en = psel && penable && pwrite;

   // hardware never touches cfg_r, so wake leaves it as written
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r <= CFG_RST;
      end else if (wr_en && paddr == ADDR_CFG) begin
         cfg_r[GATE_BIT] <= pwdata[GATE_BIT];
         cfg_r[1] <= pwdata[1];
         if (t1_oscen_r || !pwdata[SEL_LO_BIT]) begin
            cfg_r[SEL_LO_BIT] <= pwdata[SEL_LO_BIT];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t1_oscen_r <= T1_OSCEN_RST;
      end else if (wr_en && paddr == ADDR_T1) begin
         t1_oscen_r <= pwdata[T1_OSCEN_BIT];
      end
   end

   // read data captured in the setup phase, presented in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata_r <= 32'h0000_0000;
         case (paddr)
            ADDR_CFG: begin
               prdata_r[GATE_BIT] <= cfg_r[GATE_BIT];
               prdata_r[PRF_BIT] <= prf_r;
               prdata_r[ISF_BIT] <= isf_r;
               prdata_r[1:0] <= cfg_r[1:0];
            end
            ADDR_T1: begin
               prdata_r[T1_RUN_BIT] <= ssf_r;
               prdata_r[T1_OSCEN_BIT] <= t1_oscen_r;
            end
            ADDR_MODE: begin
               prdata_r[4:2] <= state_r;
               prdata_r[1:0] <= cur_src_r;
            end
            default: begin
               prdata_r <= 32'h0000_0000;
            end
         endcase
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_r;
   assign cpu_clk_en = cpu_clk_en_r;
   assign per_clk_en = per_clk_en_r;
   assign sys_src = sys_src_r;
   assign pri_osc_en = pri_osc_en_r;
   assign wdt_reset = wdt_reset_r;
   assign cpu_ready = cpu_ready_r;
endmodule

// *** rtl/pmcs_pkg.sv ***
// constants, types and decode helpers for the power mode clock selector
// assumes a 250 MHz register clock and synchronous source tick inputs
package pmcs_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses, one word each)
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_T1 = 8'h04;
   localparam logic [7:0] ADDR_MODE = 8'h08;
   // ---------------------------------------------------------------
   // field positions and reset values
   // ---------------------------------------------------------------
   localparam int GATE_BIT = 7;
   localparam int PRF_BIT = 3;
   localparam int ISF_BIT = 2;
   localparam int SEL_LO_BIT = 0;
   localparam int T1_RUN_BIT = 6;
   localparam int T1_OSCEN_BIT = 3;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic T1_OSCEN_RST = 1'b0;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int WAKE_DLY_NS = 10000;
   localparam int WAKE_DLY_CYC =
      (WAKE_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [11:0] WAKE_DLY_CNT = 12'(WAKE_DLY_CYC);
   localparam logic [3:0] SWITCH_TICKS = 4'h8;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_PRI = 2'b00,
      SRC_SEC = 2'b01,
      SRC_INT = 2'b10
   } pmcs_src_t;
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_STOP = 3'b001,
      ST_SWITCH = 3'b010,
      ST_IDLE = 3'b011,
      ST_SLEEP = 3'b100,
      ST_WAKE = 3'b101,
      ST_WAITP = 3'b110
   } pmcs_state_t;
   // select field to source: 1x is the internal block
   function automatic pmcs_src_t pmcs_src_f(input logic [1:0] sel);
      if (sel[1]) begin
         return SRC_INT;
      end else if (sel[0]) begin
         return SRC_SEC;
      end else begin
         return SRC_PRI;
      end
   endfunction
endpackage

// *** rtl/pmcs_tick_cnt.sv ***
// counts ticks of the incoming clock source during a switch
// assumes tick is a one-cycle pulse per period of that source
`timescale 1ns/1ns
module pmcs_tick_cnt (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic clr,
   input wire logic en,
   input wire logic tick,
   // result
   output logic done
);
   import pmcs_pkg::*;
   logic [3:0] cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 4'h0;
      end else if (clr) begin
         cnt_r <= 4'h0;
      end else if (en && tick && !done) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
   assign done = (cnt_r == SWITCH_TICKS);
endmodule

// *** rtl/pmcs_wake_tmr.sv ***
// cpu ready delay after a wake from an idle mode
// assumes start is a single-cycle pulse
`timescale 1ns/1ns
module pmcs_wake_tmr (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic start,
   // result
   output logic done
);
   import pmcs_pkg::*;
   logic [11:0] cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= 12'h000;
      end else if (start) begin
         cnt_r <= WAKE_DLY_CNT;
      end else if (cnt_r != 12'h000) begin
         cnt_r <= cnt_r - 12'h001;
      end
   end
   assign done = (cnt_r == 12'h001);
endmodule

// *** sim/pmcs_osc_model.sv ***
// oscillator model: source ticks and primary start-up ready
// assumes pri_osc_en comes from the selector in the pclk domain
`timescale 1ns/1ns
module pmcs_osc_model #(
   parameter int PRI_START = 3000
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic pri_osc_en,
   // source outputs
   output logic pri_ready,
   output logic pri_tick,
   output logic sec_tick,
   output logic int_tick
);
   logic [7:0] ph_r;
   int st_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_r <= 8'h00;
         st_r <= 0;
      end else begin
         ph_r <= ph_r + 8'h01;
         st_r <= pri_osc_en ? st_r + 1 : 0;
      end
   end
   // ready falls at once when the primary is shut down
   assign pri_ready = pri_osc_en && st_r >= PRI_START;
   // primary is silent while disabled, the others free-run
   assign pri_tick = pri_osc_en && ph_r[0];
   assign sec_tick = (ph_r % 8'h07) == 8'h00;
   assign int_tick = (ph_r % 8'h03) == 8'h00;
endmodule

// *** sim/pmcs_checker.sv ***
// checker: clock gating and source switching relations at the ports
// assumes a shadow of the apb config writes stands for the registers
`timescale 1ns/1ns
module pmcs_checker
   import pmcs_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   // events and sources
   input wire logic pwr_down_exec,
   input wire logic wdt_timeout,
   input wire logic pri_tick,
   input wire logic sec_tick,
   input wire logic int_tick,
   // clock control
   input wire logic cpu_clk_en,
   input wire logic per_clk_en,
   input wire logic [1:0] sys_src,
   input wire logic pri_osc_en,
   input wire logic wdt_reset
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ------
   // shadow state
   // ------
   logic gate_r, t1en_r, wr, pd_ok;
   logic [1:0] sel_r;
   logic [3:0] pc_r, sc_r, ic_r, tnew;
   function automatic logic [3:0] bump(logic [3:0] c, logic t, logic z);
      return z ? 4'h0 : c + {3'h0, t && c != 4'hF};
   endfunction
   assign wr = psel && penable && pwrite && pready;
   assign pd_ok = pwr_down_exec && cpu_clk_en;
   assign tnew = (sys_src == SRC_SEC) ? sc_r :
                 (sys_src == SRC_INT) ? ic_r : pc_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_r <= 1'b0;
         sel_r <= 2'h0;
         t1en_r <= 1'b0;
      end else if (wr && paddr == ADDR_CFG) begin
         gate_r <= pwdata[7];
         sel_r[1] <= pwdata[1];
         // low select bit refused while the secondary osc is off
         sel_r[0] <= (pwdata[0] && !t1en_r) ? sel_r[0] : pwdata[0];
      end else if (wr && paddr == ADDR_T1) begin
         t1en_r <= pwdata[3];
      end
   end
   // ticks of each source counted only while the clocks are paused
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_r <= 4'h0;
         sc_r <= 4'h0;
         ic_r <= 4'h0;
      end else begin
         pc_r <= bump(pc_r, pri_tick, per_clk_en);
         sc_r <= bump(sc_r, sec_tick, per_clk_en);
         ic_r <= bump(ic_r, int_tick, per_clk_en);
      end
   end
   // ------
   // assertions
   // ------
   stop_next_a: assert property (
      pd_ok |=> !cpu_clk_en && !per_clk_en)
      else $error("clocks not stopped after power-down");
   sleep_off_a: assert property (
      pd_ok && !gate_r && sel_r == 2'h0
      |=> !per_clk_en ##[1:2] (!pri_osc_en && !per_clk_en))
      else $error("sleep entry left a clock or the primary on");
   idle_hold_a: assert property (
      pd_ok && gate_r |=> !cpu_clk_en [*8])
      else $error("cpu clock resumed in an idle mode");
   run_both_a: assert property (
      $rose(per_clk_en) && !gate_r && sys_src != SRC_PRI |-> cpu_clk_en)
      else $error("run mode resumed without the cpu clock");
   switch_eight_a: assert property (
      $changed(sys_src) |-> tnew >= 4'h8)
      else $error("source switched before eight new ticks");
   src_quiet_a: assert property (
      $changed(sys_src) |-> !$past(per_clk_en))
      else $error("source changed while clocks were running");
   wdt_run_a: assert property (
      wdt_timeout && cpu_clk_en && per_clk_en && sys_src != SRC_PRI
      |=> wdt_reset)
      else $error("watchdog in run mode gave no reset");
   wdt_wake_a: assert property (
      wdt_timeout && !cpu_clk_en |=> !wdt_reset)
      else $error("watchdog reset while cpu was halted");
   pri_on_a: assert property (
      sys_src == SRC_PRI && per_clk_en |-> pri_osc_en)
      else $error("primary feeds the system while shut down");
   cover property (pd_ok && gate_r);
   cover property ($changed(sys_src));
   cover property (wdt_reset);
endmodule
bind pmcs_top pmcs_checker chk_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .pwr_down_exec(pwr_down_exec),
   .wdt_timeout(wdt_timeout), .pri_tick(pri_tick), .sec_tick(sec_tick),
   .int_tick(int_tick), .cpu_clk_en(cpu_clk_en), .per_clk_en(per_clk_en),
   .sys_src(sys_src), .pri_osc_en(pri_osc_en), .wdt_reset(wdt_reset));

// *** sim/pmcs_top_bench.sv ***
// testbench: config guard, idle, run, sleep and watchdog scenarios
// assumes the oscillator model supplies ticks and primary ready
`timescale 1ns/1ns
module pmcs_top_bench;
   import pmcs_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [2:0] ev = 3'h0;
   logic pready, pslverr, err, pri_ready, pri_int = 1'b0, istab = 1'b0;
   logic pri_tick, sec_tick, int_tick, pri_osc_en, wdt_reset, cpu_ready;
   logic cpu_clk_en, per_clk_en, tse = 1'b0;
   logic [1:0] sys_src;
   int bad_count = 0, total_checks = 0;
   always #2 pclk = ~pclk;
   pmcs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pwr_down_exec(ev[0]), .wake_irq(ev[1]), .wdt_timeout(ev[2]),
      .pri_ready(pri_ready), .pri_is_fast_internal_osc(pri_int),
      .fast_internal_osc_stable(istab), .two_speed_en(tse), .pri_tick(pri_tick),
      .sec_tick(sec_tick), .int_tick(int_tick), .cpu_clk_en(cpu_clk_en),
      .per_clk_en(per_clk_en), .sys_src(sys_src), .pri_osc_en(pri_osc_en),
      .wdt_reset(wdt_reset), .cpu_ready(cpu_ready));
   pmcs_osc_model osc (.pclk(pclk), .presetn(presetn),
      .pri_osc_en(pri_osc_en), .pri_ready(pri_ready),
      .pri_tick(pri_tick), .sec_tick(sec_tick), .int_tick(int_tick));
   // ------
   // shared tasks
   // ------
   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         bad_count++;
         results();
      end
   endtask
   // 0 waits for the cpu clock, 1 peripheral clock, 2 primary source
   task automatic wait_for(input int s, input int lim, output int n);
      n = 0;
      do begin
         @(posedge pclk);
         #1;
         n++;
      end while (!(s == 0 ? cpu_clk_en === 1'b1 : s == 1 ?
         per_clk_en === 1'b1 : sys_src === SRC_PRI) && n < lim);
      if (n >= lim) begin
         bad_count++;
         results();
      end
   endtask
   // one-cycle strobe: 0 power-down, 1 wake, 2 watchdog
   task automatic pulse(input int s);
      @(posedge pclk);
      ev <= 3'h1 << s;
      @(posedge pclk);
      ev <= 3'h0;
      #1;
   endtask
   // ------
   // scenarios
   // ------
   task automatic t_guard();
      apb(ADDR_CFG, 1'b1, 32'h0000_0001);
      apb(ADDR_CFG, 1'b0, 32'h0000_0000);
      chk(rd & 32'h0000_0083, 32'h0000_0000);
      apb(ADDR_T1, 1'b1, 32'h0000_0008);
      apb(ADDR_CFG, 1'b1, 32'h0000_0081);
      apb(ADDR_CFG, 1'b0, 32'h0000_0000);
      chk(rd & 32'h0000_0083, 32'h0000_0081);
      chk({cpu_clk_en, sys_src}, 32'h0000_0004);
      apb(8'h0C, 1'b0, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(err, 1'b1);
      $display("test guard done");
   endtask
   task automatic t_secondary_cpu_halted_mode();
      int n;
      pulse(0);
      chk({cpu_clk_en, per_clk_en}, 32'h0000_0000);
      wait_for(1, 500, n);
      chk({cpu_clk_en, sys_src}, 32'h0000_0001);
      apb(ADDR_MODE, 1'b0, 32'h0000_0000);
      chk(rd, {27'h0, ST_IDLE, SRC_SEC});
      apb(ADDR_T1, 1'b0, 32'h0000_0000);
      chk(rd & 32'h0000_0048, 32'h0000_0048);
      apb(ADDR_CFG, 1'b0, 32'h0000_0000);
      chk(rd & 32'h0000_000C, 32'h0000_0000);
      pulse(1);
      wait_for(0, 3000, n);
      chk(n >= 2400, 1'b1);
      chk(cpu_ready, 1'b1);
      chk(sys_src, SRC_SEC);
      wait_for(2, 5000, n);
      apb(ADDR_CFG, 1'b0, 32'h0000_0000);
      chk(rd & 32'h0000_008B, 32'h0000_0089);
      $display("test secondary idle done");
   endtask
   task automatic t_int_run();
      int n;
      logic seen;
      @(posedge pclk);
      pri_int <= 1'b1;
      istab <= 1'b1;
      apb(ADDR_CFG, 1'b0, 32'h0000_0000);
      chk(rd & 32'h0000_000C, 32'h0000_000C);
      apb(ADDR_CFG, 1'b1, 32'h0000_0002);
      pulse(0);
      wait_for(0, 500, n);
      chk({per_clk_en, sys_src}, 32'h0000_0006);
      apb(ADDR_CFG, 1'b0, 32'h0000_0000);
      chk(rd & 32'h0000_000C, 32'h0000_0004);
      pulse(2);
      seen = wdt_reset;
      @(posedge pclk);
      #1;
      seen = seen | wdt_reset;
      chk(seen, 1'b1);
      pulse(1);
      wait_for(2, 5000, n);
      chk(cpu_clk_en, 1'b1);
      @(posedge pclk);
      pri_int <= 1'b0;
      istab <= 1'b0;
      $display("test internal run done");
   endtask
   task automatic t_sleep();
      int n;
      apb(ADDR_CFG, 1'b1, 32'h0000_0000);
      pulse(0);
      repeat (2) @(posedge pclk);
      #1;
      chk({cpu_clk_en, per_clk_en, pri_osc_en}, 32'h0);
      apb(ADDR_CFG, 1'b0, 32'h0000_0000);
      chk(rd & 32'h0000_0008, 32'h0000_0000);
      pulse(2);
      chk(wdt_reset, 1'b0);
      wait_for(0, 4000, n);
      chk({per_clk_en, sys_src}, 32'h0000_0004);
      apb(ADDR_CFG, 1'b0, 32'h0000_0000);
      chk(rd & 32'h0000_0008, 32'h0000_0008);
      // two-speed start: internal clocks the wait, then primary takes over
      @(posedge pclk);
      tse <= 1'b1;
      pulse(0);
      pulse(1);
      wait_for(0, 500, n);
      chk({per_clk_en, sys_src}, 32'h0000_0006);
      wait_for(2, 5000, n);
      chk(cpu_clk_en, 1'b1);
      $display("test sleep done");
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_guard();
      t_secondary_cpu_halted_mode();
      t_int_run();
      t_sleep();
      results();
   end
endmodule
